// *** design/update_engine_pkg.sv ***
// constants and types shared by the output update timing engine
`default_nettype none
package update_engine_pkg;
  localparam int          COUNT_W            = 24;
  localparam int          SEL_W              = 4;
  localparam int          CLK_HZ             = 25_000_000;
  // timebase selection codes
  localparam logic [2:0]  TB_100MHZ          = 3'h0;
  localparam logic [2:0]  TB_20MHZ           = 3'h1;
  localparam logic [2:0]  TB_100KHZ          = 3'h2;
  localparam logic [2:0]  TB_CLK10           = 3'h3;
  localparam logic [2:0]  TB_FUNC_TERM       = 3'h4;
  localparam logic [2:0]  TB_SYNC_BUS        = 3'h5;
  localparam logic [2:0]  TB_TRIG_LINE       = 3'h6;
  localparam logic [2:0]  TB_STAR            = 3'h7;
  // update clock source selection codes
  localparam logic [3:0]  SRC_DIVIDED        = 4'h0;
  localparam logic [3:0]  SRC_CTR_OUT        = 4'h1;
  localparam logic [3:0]  SRC_CHANGE_DET     = 4'h2;
  localparam logic [3:0]  SRC_CTR_SAMPLE     = 4'h3;
  localparam logic [3:0]  SRC_CAPTURE_CLK    = 4'h4;
  localparam logic [3:0]  SRC_PORT_OUT_CLK   = 4'h5;
  localparam logic [3:0]  SRC_FUNC_TERM      = 4'h6;
  localparam logic [3:0]  SRC_SYNC_BUS       = 4'h7;
  localparam logic [3:0]  SRC_TRIG_LINE      = 4'h8;
  localparam logic [3:0]  SRC_STAR           = 4'h9;
  localparam logic [3:0]  SRC_DSTAR          = 4'ha;
  // reset values
  localparam logic [COUNT_W-1:0] START_DELAY_RESET = 24'h000002;
  localparam logic [COUNT_W-1:0] COUNT_ONE         = 24'h000001;
  localparam logic [COUNT_W-1:0] COUNT_ZERO        = 24'h000000;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN   = 2'b11,
    ST_DONE  = 2'b10
  } engine_state_t;
endpackage : update_engine_pkg
`default_nettype wire

// *** design/edge_sync_if.sv ***
// interface carrying a synchronised line and its edge pulses
`default_nettype none
interface edge_sync_if;
  logic level;
  logic rise;
  logic fall;
  modport source (output level, output rise, output fall);
  modport sink   (input level, input rise, input fall);
endinterface : edge_sync_if
`default_nettype wire

// *** design/edge_sync.sv ***
// two-stage synchroniser with edge detection
`default_nettype none
module edge_sync (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       line_i,
  edge_sync_if.source     sync
);
  logic meta_reg;
  logic meta_next;
  logic stable_reg;
  logic stable_next;
  logic last_reg;
  logic last_next;

  always_comb begin
    meta_next   = line_i;
    stable_next = meta_reg;
    last_next   = stable_reg;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_reg   <= 1'b0;
      stable_reg <= 1'b0;
      last_reg   <= 1'b0;
    end else begin
      meta_reg   <= meta_next;
      stable_reg <= stable_next;
      last_reg   <= last_next;
    end
  end

  assign sync.level = stable_reg;
  assign sync.rise  = stable_reg & ~last_reg;
  assign sync.fall  = ~stable_reg & last_reg;
endmodule : edge_sync
`default_nettype wire

// *** design/output_update_timing_engine.sv ***
// output update timing engine: timebase, divider, start delay, pause, finite count
`default_nettype none
module output_update_timing_engine
  import update_engine_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  input  wire logic                tb_100mhz_i,
  input  wire logic                tb_20mhz_i,
  input  wire logic                tb_100khz_i,
  input  wire logic                tb_clk10_i,
  input  wire logic                func_term_i,
  input  wire logic                sync_bus_i,
  input  wire logic                trig_line_i,
  input  wire logic                star_i,
  input  wire logic                dstar_i,
  input  wire logic                ctr_out_i,
  input  wire logic                change_det_i,
  input  wire logic                ctr_sample_i,
  input  wire logic                input_capture_clock_i,
  input  wire logic                port_output_clock_i,
  input  wire logic                output_start_trigger_i,
  input  wire logic                output_pause_input_i,
  input  wire logic                sw_start_i,
  input  wire logic                sw_stop_i,
  input  wire logic [2:0]          timebase_sel_i,
  input  wire logic                timebase_falling_i,
  input  wire logic [SEL_W-1:0]    clock_sel_i,
  input  wire logic                clock_falling_i,
  input  wire logic                start_falling_i,
  input  wire logic                pause_active_low_i,
  input  wire logic [COUNT_W-1:0]  divisor_i,
  input  wire logic [COUNT_W-1:0]  start_delay_i,
  input  wire logic                delay_load_i,
  input  wire logic                finite_i,
  input  wire logic                retrigger_i,
  input  wire logic [COUNT_W-1:0]  sample_count_i,
  input  wire logic                export_en_i,
  output logic                     bank_update_o,
  output logic                     output_update_clock_o,
  output logic                     output_update_clock_oe_o,
  output logic                     running_o,
  output logic                     done_o,
  output logic [COUNT_W-1:0]       samples_o
);
  //////////////////////////////////////////////////////////////////////////
  // synchronisers for every outside line
  localparam int NLINES = 16;
  logic [NLINES-1:0] raw_lines;
  logic [NLINES-1:0] lvl;
  logic [NLINES-1:0] rise;
  logic [NLINES-1:0] fall;

  assign raw_lines = {output_pause_input_i, output_start_trigger_i, port_output_clock_i,
                      input_capture_clock_i, ctr_sample_i, change_det_i, ctr_out_i,
                      dstar_i, star_i, trig_line_i, sync_bus_i, func_term_i,
                      tb_clk10_i, tb_100khz_i, tb_20mhz_i, tb_100mhz_i};

  for (genvar g = 0; g < NLINES; g++) begin : g_sync
    edge_sync_if s ();
    edge_sync u_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .line_i  (raw_lines[g]),
      .sync    (s.source)
    );
    assign lvl[g]  = s.level;
    assign rise[g] = s.rise;
    assign fall[g] = s.fall;
  end

  //////////////////////////////////////////////////////////////////////////
  // timebase tick selection, from internal and external lines
  logic [3:0] tb_idx;
  logic       tb_tick;
  logic [3:0] clk_idx;
  logic       src_edge;
  logic       start_edge;
  logic       paused;
  logic       is_internal;

  always_comb begin
    unique case (timebase_sel_i)
      TB_100MHZ:    tb_idx = 4'h0;
      TB_20MHZ:     tb_idx = 4'h1;
      TB_100KHZ:    tb_idx = 4'h2;
      TB_CLK10:     tb_idx = 4'h3;
      TB_FUNC_TERM: tb_idx = 4'h4;
      TB_SYNC_BUS:  tb_idx = 4'h5;
      TB_TRIG_LINE: tb_idx = 4'h6;
      TB_STAR:      tb_idx = 4'h7;
    endcase
    tb_tick = timebase_falling_i ? fall[tb_idx] : rise[tb_idx];
  end

  always_comb begin
    clk_idx     = 4'h0;
    is_internal = 1'b0;
    unique case (clock_sel_i)
      SRC_DIVIDED:      is_internal = 1'b1;
      SRC_CTR_OUT:      clk_idx = 4'h9;
      SRC_CHANGE_DET:   clk_idx = 4'ha;
      SRC_CTR_SAMPLE:   clk_idx = 4'hb;
      SRC_CAPTURE_CLK:  clk_idx = 4'hc;
      SRC_PORT_OUT_CLK: clk_idx = 4'hd;
      SRC_FUNC_TERM:    clk_idx = 4'h4;
      SRC_SYNC_BUS:     clk_idx = 4'h5;
      SRC_TRIG_LINE:    clk_idx = 4'h6;
      SRC_STAR:         clk_idx = 4'h7;
      SRC_DSTAR:        clk_idx = 4'h8;
      default:          is_internal = 1'b1;
    endcase
    src_edge   = clock_falling_i ? fall[clk_idx] : rise[clk_idx];
    start_edge = sw_start_i | (start_falling_i ? fall[14] : rise[14]);
    paused     = lvl[15] ^ pause_active_low_i;
  end

  //////////////////////////////////////////////////////////////////////////
  // engine state, divider, delay and sample counters
  engine_state_t      state_reg;
  engine_state_t      state_next;
  logic [COUNT_W-1:0] div_reg;
  logic [COUNT_W-1:0] div_next;
  logic [COUNT_W-1:0] delay_cfg_reg;
  logic [COUNT_W-1:0] delay_cfg_next;
  logic [COUNT_W-1:0] delay_reg;
  logic [COUNT_W-1:0] delay_next;
  logic [COUNT_W-1:0] samp_reg;
  logic [COUNT_W-1:0] samp_next;
  logic               upd_reg;
  logic               upd_next;
  logic               clk_out_reg;
  logic               clk_out_next;
  logic               tick;

  always_comb begin
    state_next     = state_reg;
    div_next       = div_reg;
    delay_next     = delay_reg;
    samp_next      = samp_reg;
    upd_next       = 1'b0;
    tick           = 1'b0;
    delay_cfg_next = delay_load_i ? start_delay_i : delay_cfg_reg;
    unique case (state_reg)
      // start launches; triggers taken when idle, or when done with retrigger_i set
      ST_IDLE: begin
        if (start_edge) begin
          state_next = ST_DELAY;
          delay_next = delay_cfg_reg;
          samp_next  = COUNT_ZERO;
          div_next   = COUNT_ZERO;
        end
      end
      ST_DELAY: begin
        if (tb_tick) begin
          if (delay_reg <= COUNT_ONE) begin
            state_next = ST_RUN;
          end else begin
            delay_next = delay_reg - COUNT_ONE;
          end
        end
      end
      ST_RUN: begin
        // divided internal pulses; external edge otherwise
        if (is_internal) begin
          if (tb_tick) begin
            if (div_reg == COUNT_ZERO) begin
              tick     = 1'b1;
              div_next = (divisor_i > COUNT_ONE) ? divisor_i - COUNT_ONE : COUNT_ZERO;
            end else begin
              div_next = div_reg - COUNT_ONE;
            end
          end
        end else begin
          // other sources resume only on a fresh edge
          tick = src_edge;
        end
        if (tick) begin
          // pause masks the strobe; count still advances
          upd_next  = ~paused;
          samp_next = samp_reg + COUNT_ONE;
          if (finite_i && (samp_reg + COUNT_ONE >= sample_count_i)) begin
            state_next = retrigger_i ? ST_IDLE : ST_DONE;
          end
        end
      end
      ST_DONE: begin
        if (start_edge && retrigger_i) begin
          state_next = ST_DELAY;
          delay_next = delay_cfg_reg;
          samp_next  = COUNT_ZERO;
        end
      end
    endcase
    if (sw_stop_i) begin
      state_next = ST_IDLE;
    end
    // active-low export, one clock cycle wide low
    clk_out_next = ~upd_next;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg     <= ST_IDLE;
      div_reg       <= COUNT_ZERO;
      delay_cfg_reg <= START_DELAY_RESET;
      delay_reg     <= COUNT_ZERO;
      samp_reg      <= COUNT_ZERO;
      upd_reg       <= 1'b0;
      clk_out_reg   <= 1'b1;
    end else begin
      state_reg     <= state_next;
      div_reg       <= div_next;
      delay_cfg_reg <= delay_cfg_next;
      delay_reg     <= delay_next;
      samp_reg      <= samp_next;
      upd_reg       <= upd_next;
      clk_out_reg   <= clk_out_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  // one strobe for all banks
  assign bank_update_o            = upd_reg;
  // only the update clock leaves, never the timebase
  assign output_update_clock_o    = clk_out_reg;
  assign output_update_clock_oe_o = export_en_i;
  assign running_o                = (state_reg == ST_DELAY) || (state_reg == ST_RUN);
  assign done_o                   = (state_reg == ST_DONE);
  assign samples_o                = samp_reg;

  //////////////////////////////////////////////////////////////////////////
  // assertions
  a_pause_masks_update: assert property (@(posedge clk_i) disable iff (reset_i)
    ($past(paused) && $past(state_reg) == ST_RUN) |-> !bank_update_o)
    else $error("update issued while paused");
  a_count_in_pause: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_reg == ST_RUN && tick && !sw_stop_i) |=> samp_reg == $past(samp_reg) + COUNT_ONE)
    else $error("sample count did not advance");
  a_delay_reset_two: assert property (@(posedge clk_i)
    $past(reset_i) && !$past(delay_load_i) |-> delay_cfg_reg == START_DELAY_RESET)
    else $error("start delay default wrong");
  a_ignore_retrigger: assert property (@(posedge clk_i) disable iff (reset_i)
    (running_o && !(state_reg == ST_RUN && tick) && start_edge && !sw_stop_i) |=> running_o)
    else $error("trigger restarted a running burst");
  a_finite_stops: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_reg == ST_RUN && tick && finite_i && !retrigger_i
     && samp_reg + COUNT_ONE >= sample_count_i && !sw_stop_i) |=> done_o)
    else $error("finite run did not complete");
  a_export_low: assert property (@(posedge clk_i) disable iff (reset_i)
    bank_update_o |-> !output_update_clock_o)
    else $error("exported clock not active low");
  a_sw_stop_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    sw_stop_i |=> state_reg == ST_IDLE ##1 !bank_update_o)
    else $error("software stop ignored");
  a_delay_first: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_reg == ST_IDLE && start_edge && !sw_stop_i) |=> state_reg == ST_DELAY)
    else $error("start did not enter delay");
  a_update_needs_run: assert property (@(posedge clk_i) disable iff (reset_i)
    bank_update_o |-> $past(state_reg) == ST_RUN)
    else $error("update outside a run");
  c_finite_done: cover property (@(posedge clk_i) disable iff (reset_i) $rose(done_o));
  c_paused_tick: cover property (@(posedge clk_i) disable iff (reset_i) tick && paused);
  c_external_upd: cover property (@(posedge clk_i) disable iff (reset_i)
    bank_update_o && $past(!is_internal));
endmodule : output_update_timing_engine
`default_nettype wire

// *** test/far_side_model.sv ***
// far-side model: timebase and source lines, converter bank update counter
`default_nettype none
module far_side_model (
  input  wire logic clk_i,
  input  wire logic bank_update_i,
  output logic      tick_o,
  output logic      ext_clk_o,
  output int        updates_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph;
  initial begin
    ph = 0;
    tick_o = 1'b0;
    ext_clk_o = 1'b0;
    updates_o = 0;
  end
  // free lines, undivided source held six cycles per level
  always @(negedge clk_i) begin
    ph <= ph + 1;
    if (ph % 4 == 3) tick_o <= ~tick_o;
    if (ph % 6 == 5) ext_clk_o <= ~ext_clk_o;
  end
  // one strobe updates every running bank
  always @(posedge clk_i) begin
    if (bank_update_i === 1'b1) updates_o <= updates_o + 1;
  end
endmodule // far_side_model
`default_nettype wire

// *** test/output_update_timing_engine_tb.sv ***
// self-checking bench for the output update timing engine
`default_nettype none
module output_update_timing_engine_tb;
  import update_engine_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, reset_i, tick, ext, sw_start, sw_stop, trig, pause, tfall, cfall, sfall, pal;
  logic dload, fin, retr, exp_en, upd, uclk, uoe, run, done;
  logic [2:0] tsel;
  logic [SEL_W-1:0] csel;
  logic [COUNT_W-1:0] div, dly, cnt, smp;
  int fails, num_checks, ups, u0, l2, pcnt;
  output_update_timing_engine dut (.clk_i(clk_i), .reset_i(reset_i), .tb_100mhz_i(tick),
    .tb_20mhz_i(tick), .tb_100khz_i(tick), .tb_clk10_i(tick), .func_term_i(ext),
    .sync_bus_i(ext), .trig_line_i(ext), .star_i(ext), .dstar_i(ext), .ctr_out_i(ext),
    .change_det_i(ext), .ctr_sample_i(ext), .input_capture_clock_i(ext),
    .port_output_clock_i(ext), .output_start_trigger_i(trig), .output_pause_input_i(pause),
    .sw_start_i(sw_start), .sw_stop_i(sw_stop), .timebase_sel_i(tsel),
    .timebase_falling_i(tfall), .clock_sel_i(csel), .clock_falling_i(cfall),
    .start_falling_i(sfall), .pause_active_low_i(pal), .divisor_i(div),
    .start_delay_i(dly), .delay_load_i(dload), .finite_i(fin), .retrigger_i(retr),
    .sample_count_i(cnt), .export_en_i(exp_en), .bank_update_o(upd),
    .output_update_clock_o(uclk), .output_update_clock_oe_o(uoe), .running_o(run),
    .done_o(done), .samples_o(smp));
  far_side_model far (.clk_i(clk_i), .bank_update_i(upd), .tick_o(tick), .ext_clk_o(ext),
    .updates_o(ups));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [COUNT_W-1:0] seen, input logic [COUNT_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic go();
    u0 = ups;
    sw_start = 1'b1;
    cyc(1);
    sw_start = 1'b0;
  endtask
  task automatic stop();
    sw_stop = 1'b1;
    cyc(1);
    sw_stop = 1'b0;
    cyc(1);
  endtask
  task automatic fire();
    trig = 1'b1;
    cyc(3);
    trig = 1'b0;
    cyc(3);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (run !== 1'b0 && k < 4000) begin
      cyc(1);
      k++;
    end
    // let the last strobe reach the bank model
    cyc(1);
    if (k == 4000) begin
      fails++;
      $display("mismatch at %0t: engine never went idle", $time);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // exported clock low exactly with the bank strobe
  always @(negedge clk_i) if (reset_i === 1'b0) check(uclk, 1'(~upd));
  // no strobe once pause has settled
  always @(negedge clk_i) begin
    pcnt <= (pause ^ pal) ? pcnt + 1 : 0;
    if (pcnt > 5) check(upd, 1'b0);
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    {fails, num_checks, pcnt} = '0;
    {reset_i, sw_start, sw_stop, trig, pause, tfall, cfall, sfall, pal} = 9'h100;
    {dload, fin, retr, exp_en} = '0;
    tsel = TB_100MHZ;
    csel = SRC_DIVIDED;
    div = 24'h000002;
    dly = START_DELAY_RESET;
    cnt = 24'h000003;
    cyc(8);
    reset_i = 1'b0;
    check(upd, 1'b0);
    check(uclk, 1'b1);
    check({run, done}, 2'b00);
    check(smp, COUNT_ZERO);
    $display("test reset done");
    // every timebase, divided by two, three samples
    fin = 1'b1;
    for (int t = 0; t < 8; t++) begin
      tsel = t[2:0];
      tfall = t[0];
      go();
      check(run, 1'b1);
      wait_idle();
      check(24'(ups - u0), 24'h000003);
      check(smp, 24'h000003);
      check(done, 1'b1);
      stop();
      check(done, 1'b0);
    end
    tsel = TB_100MHZ;
    tfall = 1'b0;
    $display("test timebase done");
    // four extra delay ticks add four timebase periods
    div = 24'h000001;
    cnt = 24'h000001;
    for (int d = 0; d < 2; d++) begin
      @(posedge tick);
      cyc(1);
      go();
      l2 = d ? l2 - 1 : 1;
      while (upd !== 1'b1 && l2 > -400 && l2 < 400) begin
        cyc(1);
        l2 = d ? l2 - 1 : l2 + 1;
      end
      wait_idle();
      stop();
      dly = 24'h000006;
      dload = 1'b1;
      cyc(1);
      dload = 1'b0;
    end
    check(24'(-l2), 24'd32);
    dly = START_DELAY_RESET;
    dload = 1'b1;
    cyc(1);
    dload = 1'b0;
    $display("test delay done");
    // every other source, odd codes on the falling edge, even codes on the rising, continuous
    fin = 1'b0;
    for (int s = 1; s < 11; s++) begin
      csel = s[SEL_W-1:0];
      cfall = s[0];
      go();
      cyc(60);
      stop();
      check(run, 1'b0);
      check((ups - u0) inside {[2:6]}, 1'b1);
    end
    csel = SRC_DIVIDED;
    cfall = 1'b0;
    $display("test sources done");
    // pause masks strobes but samples still advance
    fin = 1'b1;
    cnt = 24'h00000a;
    pal = 1'b1;
    pause = 1'b1;
    go();
    cyc(20);
    pause = 1'b0;
    cyc(32);
    pause = 1'b1;
    wait_idle();
    check(smp, 24'h00000a);
    check((ups - u0) < 10, 1'b1);
    stop();
    {pal, pause} = 2'b00;
    $display("test pause done");
    // triggers during a burst are ignored, engine rearms
    retr = 1'b1;
    cnt = 24'h000003;
    u0 = ups;
    fire();
    check(run, 1'b1);
    fire();
    wait_idle();
    sfall = 1'b1;
    fire();
    wait_idle();
    sfall = 1'b0;
    check(24'(ups - u0), 24'h000006);
    check(done, 1'b0);
    retr = 1'b0;
    $display("test retrigger done");
    // export enable drives the pin enable only
    exp_en = 1'b1;
    cyc(1);
    check(uoe, 1'b1);
    exp_en = 1'b0;
    cyc(1);
    check(uoe, 1'b0);
    $display("test export done");
    summarize();
  end
endmodule // output_update_timing_engine_tb
`default_nettype wire
